// >>> hdl/bridge_command_register.sv
module bridge_command_register
	import bridge_cmd_pkg::*;
#(
	parameter int ERR_SOURCES = ERR_SOURCES_DEF
) (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	// Configuration access
	input  wire cfg_req_t               cfg_req,
	output logic [15:0]                 cfg_rdata,
	output logic                        cfg_rvalid,
	output logic [15:0]                 bridge_command,
	// Bridge error conditions and their own enables
	input  wire logic [ERR_SOURCES-1:0] err_event,
	input  wire logic [ERR_SOURCES-1:0] err_enable,
	// Host-bridge function error path
	input  wire logic                   host_syserr_enable,
	input  wire logic                   host_err,
	// Hub message request and status report
	output logic                        syserr_msg,
	output logic                        syserr_from_bridge,
	// Master frame cycles
	input  wire logic                   frame_start,
	input  wire logic                   frame_hit,
	output logic                        frame_accept,
	output logic                        frame_master_abort,
	// Sideband and pipe requests
	input  wire logic                   sideband_req,
	output logic                        sideband_accept,
	// Memory window decode
	input  wire logic                   mem_range_hit,
	input  wire logic                   prefetch_range_hit,
	input  wire logic                   vga_hit,
	output logic                        mem_claim,
	// I/O window decode
	input  wire logic                   io_range_hit,
	output logic                        io_claim
);

	// Refuse source counts the error gating cannot serve
	if (ERR_SOURCES < 1 || ERR_SOURCES > ERR_SOURCES_MAX) begin : g_bad
		$error("ERR_SOURCES out of range");
	end

	state_t                 st;      // Registered state
	state_t                 next_st; // Next state
	logic [ERR_SOURCES-1:0] gated;   // Individually enabled errors
	logic                   cfg_hit; // Access addresses this word
	logic                   br_err;  // Any enabled bridge error
	logic [15:0]            view;    // Word as software sees it

	// Per-source gating by each condition's own enable
	// A condition with its own enable off never reaches the message path
	for (genvar i = 0; i < ERR_SOURCES; i++) begin : g_err
		assign gated[i] = err_event[i] & err_enable[i];
	end

	// Word-aligned decode; either byte of the word hits
	// Bit 0 of the offset is left out so both byte offsets select the word
	assign cfg_hit = (cfg_req.addr[7:1] == CMD_OFFSET[7:1]);
	assign br_err  = |gated;

	// Read view: unimplemented and reserved bits stay zero
	// Built from the state alone, so a write shows one cycle later
	always_comb begin
		view              = CMD_RESET;
		view[IO_BIT]      = st.io_en;
		view[MEM_BIT]     = st.mem_en;
		view[MASTER_BIT]  = st.master_en;
		view[SYSERR_BIT]  = st.syserr_en;
	end

	// Next state: register writes, read answer, error messages
	// A read beside a write takes the view from before that write lands
	always_comb begin
		next_st            = st;
		// Read answers one cycle later; a miss reads zero
		next_st.rvalid     = cfg_req.read;
		if (cfg_req.read) begin
			next_st.rdata  = cfg_hit ? (view & CMD_WR_MASK) : 16'h0000;
		end
		// Only writable bits are stored; the rest drop away
		if (cfg_req.write && cfg_hit) begin
			if (cfg_req.byte_en[LANE_LO]) begin
				next_st.io_en     = cfg_req.wdata[IO_BIT];
				next_st.mem_en    = cfg_req.wdata[MEM_BIT];
				next_st.master_en = cfg_req.wdata[MASTER_BIT];
			end
			if (cfg_req.byte_en[LANE_HI]) begin
				next_st.syserr_en = cfg_req.wdata[SYSERR_BIT];
			end
		end
		// Bridge errors count only under the bridge enable
		next_st.bridge_sse = st.syserr_en & br_err;
		// Host errors ride on the same message path
		next_st.msg        = (st.syserr_en & br_err) |
		                     (host_syserr_enable & host_err);
	end

	// State register; async reset loads constants only
	// One wide register keeps every flop on the same reset and clock
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st            <= '0;
			st.syserr_en  <= CMD_RESET[SYSERR_BIT];
			st.master_en  <= CMD_RESET[MASTER_BIT];
			st.mem_en     <= CMD_RESET[MEM_BIT];
			st.io_en      <= CMD_RESET[IO_BIT];
		end else begin
			st            <= next_st;
		end
	end

	// Register-driven outputs
	assign cfg_rdata          = st.rdata;
	assign cfg_rvalid         = st.rvalid;
	assign bridge_command     = view;
	// The hub message is the only error signalling path
	// Message and status pulse leave on the same edge
	assign syserr_msg         = st.msg;
	assign syserr_from_bridge = st.bridge_sse;

	// Frame cycles gated by the master enable
	assign frame_accept       = frame_start & frame_hit & st.master_en;
	// Without a claim the master times out into abort
	// Abort also covers decode misses, not only a disabled master
	assign frame_master_abort = frame_start & ~frame_accept;
	// Sideband and pipe traffic is never gated here
	assign sideband_accept    = sideband_req;

	// Window claims; the ranges themselves live elsewhere
	// A claim needs both the enable and an outside range hit
	assign mem_claim = st.mem_en &
	                   (mem_range_hit | prefetch_range_hit | vga_hit);
	assign io_claim  = st.io_en & io_range_hit;

	// Checks, all in the core clock domain
	// Every check watches what this block drives
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// A full write to this word
	sequence s_write_all;
		cfg_req.write && cfg_hit && (cfg_req.byte_en == 2'h3);
	endsequence

	// A plain read of this word, with no write beside it
	sequence s_read_only;
		cfg_req.read && cfg_hit && !cfg_req.write;
	endsequence

	// Full write, then a plain read on the very next edge;
	// the read must already see the freshly written word
	sequence s_write_then_read;
		s_write_all ##1 s_read_only;
	endsequence

	// An enabled bridge error while the bridge message enable is on
	sequence s_bridge_err;
		st.syserr_en && br_err;
	endsequence

	// A write that carries only the low byte lane;
	// the message enable in the high lane must not move
	sequence s_write_lo_only;
		cfg_req.write && cfg_hit && (cfg_req.byte_en == 2'h1);
	endsequence

	// Any of the three memory windows is hit in this cycle
	sequence s_mem_request;
		mem_range_hit || prefetch_range_hit || vga_hit;
	endsequence

	// Unimplemented fast back-to-back and stepping bits
	chk_fb2b_step_zero: assert property (
		cfg_rvalid |-> (cfg_rdata[FB2B_BIT] == 1'b0 && cfg_rdata[STEP_BIT] == 1'b0))
		else $error("fast back-to-back or stepping bit read as one");

	// Parity response cannot be turned on, neither in reads nor view
	chk_parity_zero: assert property (
		cfg_rvalid |-> !cfg_rdata[PARITY_BIT] && !bridge_command[PARITY_BIT])
		else $error("parity response enable read as one");

	// Write-invalidate and special cycle stay zero on reads
	chk_ro_bits_zero: assert property (
		cfg_rvalid |-> (cfg_rdata[MWI_BIT] == 1'b0 && cfg_rdata[SPECIAL_BIT] == 1'b0))
		else $error("write-invalidate or special cycle bit set");

	// Read-back right after a full write keeps only writable bits
	chk_reserved_zero: assert property (
		s_write_then_read |=> cfg_rvalid
		##0 (cfg_rdata == ($past(cfg_req.wdata, 2) & CMD_WR_MASK)))
		else $error("read back differs from masked write");

	// An enabled bridge error leaves as message and status pulse
	chk_syserr_send: assert property (
		s_bridge_err |=> syserr_msg && syserr_from_bridge)
		else $error("enabled bridge error sent no message");

	// Bridge enable off: no bridge status pulse whatever the errors
	chk_syserr_quiet: assert property (
		!bridge_command[SYSERR_BIT] |=> !syserr_from_bridge)
		else $error("bridge message while bridge enable off");

	// Host errors alone still reach the hub, but never as bridge errors
	chk_host_or_path: assert property (
		(!bridge_command[SYSERR_BIT] && host_syserr_enable && host_err)
		|=> syserr_msg && !syserr_from_bridge)
		else $error("host error path wrong");

	// No message ever goes out without an enabled cause
	chk_no_cause_msg: assert property (
		(!(st.syserr_en && br_err) && !(host_syserr_enable && host_err))
		|=> !syserr_msg)
		else $error("message without enabled cause");

	// A hitting frame is accepted exactly when the master enable is on
	chk_frame_gate: assert property (
		(frame_start && frame_hit) |-> (frame_accept == bridge_command[MASTER_BIT]))
		else $error("frame accept ignores master enable");

	// First edge out of reset: frames still see a master abort
	chk_reset_abort: assert property (
		($fell(rst) ##0 frame_start ##0 !bridge_command[MASTER_BIT])
		|-> frame_master_abort)
		else $error("frame accepted after reset");

	// Sideband and pipe requests pass whatever the master enable
	chk_sideband_free: assert property (
		sideband_req |-> sideband_accept)
		else $error("sideband request was gated");

	// Memory window hits are claimed exactly under the memory enable
	chk_mem_gate: assert property (
		s_mem_request |-> (mem_claim == bridge_command[MEM_BIT]))
		else $error("memory claim ignores memory enable");

	// I/O window hits are claimed exactly under the I/O enable
	chk_io_gate: assert property (
		io_range_hit |-> (io_claim == bridge_command[IO_BIT]))
		else $error("I/O claim ignores I/O enable");

	// Further checks on decode, status and the config port
	// I/O decode off: no I/O window is claimed
	chk_io_off: assert property (
		!bridge_command[IO_BIT] |-> !io_claim)
		else $error("I/O claimed with decode disabled");

	// Memory decode off: no memory window is claimed
	chk_mem_off: assert property (
		!bridge_command[MEM_BIT] |-> !mem_claim)
		else $error("memory claimed with decode disabled");

	// The status pulse only ever rides with a hub message
	chk_status_with_msg: assert property (
		syserr_from_bridge |-> syserr_msg)
		else $error("bridge status set without a message");

	// Abort is exactly a frame that was not accepted
	chk_abort_form: assert property (
		frame_master_abort == (frame_start && !frame_accept))
		else $error("master abort does not follow missed frame");

	// Every read strobe gets its answer on the next edge
	chk_read_answer: assert property (
		cfg_req.read |=> cfg_rvalid)
		else $error("read strobe got no answer");

	// A read beside a write returns the word from before the write
	chk_read_old_word: assert property (
		(cfg_req.read && cfg_req.write && cfg_hit)
		|=> (cfg_rdata == ($past(bridge_command) & CMD_WR_MASK)))
		else $error("read beside a write did not return the old word");

	// A low-lane write leaves the message enable alone
	chk_lane_lo_keep: assert property (
		s_write_lo_only |=> $stable(bridge_command[SYSERR_BIT]))
		else $error("low lane write changed the message enable");

	// Reserved and unimplemented bits never show in the view
	chk_view_reserved: assert property (
		(bridge_command & ~CMD_WR_MASK) == 16'h0000)
		else $error("unimplemented command bit reads as one");

endmodule // bridge_command_register

// >>> hdl/bridge_cmd_pkg.sv
package bridge_cmd_pkg;

	// Configuration offset of the bridge command word
	localparam logic [7:0]  CMD_OFFSET   = 8'h04;
	// Value after reset: every enable off
	localparam logic [15:0] CMD_RESET    = 16'h0000;
	// Bits software can change; all others read zero
	localparam logic [15:0] CMD_WR_MASK  = 16'h0107;

	// Field positions inside the command word
	localparam int IO_BIT      = 0;
	localparam int MEM_BIT     = 1;
	localparam int MASTER_BIT  = 2;
	localparam int SPECIAL_BIT = 3;
	localparam int MWI_BIT     = 4;
	localparam int PARITY_BIT  = 6;
	localparam int STEP_BIT    = 7;
	localparam int SYSERR_BIT  = 8;
	localparam int FB2B_BIT    = 9;

	// Byte lanes of the 16-bit configuration word
	localparam int LANE_LO     = 0;
	localparam int LANE_HI     = 1;

	// Bridge error sources, limits of the parameter
	localparam int ERR_SOURCES_DEF = 2;
	localparam int ERR_SOURCES_MAX = 8;

	// One configuration access, offered for one cycle
	typedef struct packed {
		logic        write;   // Write strobe
		logic        read;    // Read strobe
		logic [7:0]  addr;    // Byte offset
		logic [1:0]  byte_en; // Byte enables
		logic [15:0] wdata;   // Write data
	} cfg_req_t;

	// Whole state of the command register block
	typedef struct packed {
		logic        syserr_en; // Bridge system-error enable
		logic        master_en; // Bridge master enable
		logic        mem_en;    // Memory decode enable
		logic        io_en;     // I/O decode enable
		logic [15:0] rdata;     // Read data holding register
		logic        rvalid;    // Read answer pulse
		logic        msg;       // System-error message request
		logic        bridge_sse;// Bridge error was signalled
	} state_t;

endpackage

// >>> tb/hub_model.sv
// Receiving hub: counts system-error messages from the bridge
module hub_model (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Message request from the bridge
	input  wire logic syserr_msg,
	// Messages seen so far
	output int        msg_count
);
	timeunit 1ns;
	timeprecision 1ps;

	// One message per cycle of request; no side pin exists to watch
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			msg_count <= 0;
		end else if (syserr_msg) begin
			msg_count <= msg_count + 1;
		end
	end
endmodule // hub_model

// >>> tb/testbench.sv
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end
module testbench import bridge_cmd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// Clock, reset and config port
	logic        core_clk = 0;
	logic        rst      = 1;
	cfg_req_t    req      = '0;
	logic [15:0] rdata, cmd, q;
	logic        rvalid, msg, sse, fa, fma, sba, mc, ic;
	// Error sources and decode stimulus
	logic [1:0]  ev = '0, en = '0;
	logic        he = 0, herr = 0;
	logic [6:0]  dv = '0; // frame, hit, sideband, mem, prefetch, vga, io
	int          err_count = 0, num_checks = 0, hub_n;

	// 100 MHz clock
	always #5 core_clk = ~core_clk;

	bridge_command_register dut (.core_clk(core_clk), .rst(rst),
		.cfg_req(req), .cfg_rdata(rdata), .cfg_rvalid(rvalid),
		.bridge_command(cmd), .err_event(ev), .err_enable(en),
		.host_syserr_enable(he), .host_err(herr), .syserr_msg(msg),
		.syserr_from_bridge(sse), .frame_start(dv[6]), .frame_hit(dv[5]),
		.frame_accept(fa), .frame_master_abort(fma), .sideband_req(dv[4]),
		.sideband_accept(sba), .mem_range_hit(dv[3]),
		.prefetch_range_hit(dv[2]), .vga_hit(dv[1]), .mem_claim(mc),
		.io_range_hit(dv[0]), .io_claim(ic));
	hub_model hub (.core_clk(core_clk), .rst(rst), .syserr_msg(msg),
		.msg_count(hub_n));

	// Write strobe held for one rising edge only
	task automatic wr(input logic [15:0] d, input logic [1:0] be);
		@(negedge core_clk) req = '{1'b1, 1'b0, 8'h04, be, d};
		@(negedge core_clk) req = '0;
	endtask

	// Read answer lands one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge core_clk) req = '{1'b0, 1'b1, a, 2'h3, 16'h0000};
		@(negedge core_clk) req = '0;
		`CHK(rvalid, 1'b1)
		d = rdata;
	endtask

	// Decode is combinational: let it settle, then compare all outputs
	task automatic look(input logic [6:0] v, input logic [4:0] e);
		@(negedge core_clk) dv = v;
		#1 `CHK({fa, fma, sba, mc, ic}, e)
		// Stimulus drops on the next falling edge, never between edges
		@(negedge core_clk) dv = '0;
	endtask

	// One cycle of cause, answer seen one cycle later
	task automatic cause(input logic [1:0] e, g, input logic h,
		input logic [1:0] x);
		@(negedge core_clk) begin
			ev = e;
			en = g;
			herr = h;
		end
		@(negedge core_clk) `CHK({msg, sse}, x)
		ev = '0;
		en = '0;
		herr = 0;
	endtask

	// Verdict in one place
	task automatic final_report();
		$display("Checks %0d, errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog: tests need well under a thousand cycles
	initial begin
		#20000;
		err_count++;
		final_report();
	end

	// Main sequence
	initial begin
		repeat (20) @(negedge core_clk);
		rst = 0;
		dv  = 7'h60; // Frame on the very first edge out of reset
		#1 `CHK({fa, fma}, 2'b01)
		@(negedge core_clk) dv = '0;
		rd(8'h04, q); `CHK(q, 16'h0000)
		wr(16'hFFFF, 2'h3);
		rd(8'h04, q); `CHK(q, 16'h0107)
		wr(16'h0000, 2'h1);
		rd(8'h04, q); `CHK(q, 16'h0100)
		// Only the message enable on: no claims, frames aborted
		look(7'h7F, 5'b01100);
		cause(2'h1, 2'h1, 0, 2'b11);
		// The hub counts on the edge after the pulse shows
		@(negedge core_clk) `CHK(hub_n, 1)
		cause(2'h2, 2'h1, 0, 2'b00);
		// All enables on
		wr(16'h0107, 2'h3);
		look(7'h60, 5'b10000);
		look(7'h40, 5'b01000);
		look(7'h10, 5'b00100);
		for (int i = 1; i < 4; i++) begin
			look(7'h01 << i, 5'b00010);
		end
		look(7'h01, 5'b00001);
		// Bridge message enable off, host path alone
		wr(16'h0007, 2'h3);
		cause(2'h3, 2'h3, 0, 2'b00);
		@(negedge core_clk) `CHK(hub_n, 1)
		he = 1;
		cause(2'h3, 2'h3, 1, 2'b10);
		cause(2'h3, 2'h3, 0, 2'b00);
		he = 0;
		cause(2'h0, 2'h0, 1, 2'b00);
		// Read beside a write gives the old word, the next read the new one
		@(negedge core_clk) req = '{1'b1, 1'b1, 8'h05, 2'h3, 16'hFFF9};
		@(negedge core_clk) req = '{1'b0, 1'b1, 8'h04, 2'h3, 16'h0000};
		`CHK({rvalid, rdata}, 17'h10007)
		@(negedge core_clk) req = '0;
		`CHK({rvalid, rdata}, 17'h10101)
		// Other offsets read zero even with enables on
		rd(8'h06, q); `CHK(q, 16'h0000)
		// Reset again mid-run: every enable drops back off
		rst = 1;
		@(negedge core_clk) rst = 0;
		rd(8'h04, q); `CHK(q, 16'h0000)
		final_report();
	end
endmodule // testbench
